/* core/fcp_pkg.sv */
/*
 * Shared constants and types for the file control parameter template encoder.
 * Assumes the encoder and the characteristics formatter import the whole package.
 */
package fcp_pkg;

	// Object tags
	localparam logic [7:0] TAG_NAME = 8'h84;
	localparam logic [7:0] TAG_PROP = 8'hA5;
	localparam logic [7:0] TAG_CHR  = 8'h80;
	localparam logic [7:0] TAG_PWR  = 8'h81;
	localparam logic [7:0] TAG_FRQ  = 8'h82;
	localparam logic [7:0] TAG_MEM  = 8'h83;
	localparam logic [7:0] PRV_MASK = 8'hC0; // Private tags have b8 and b7 set

	// Fixed value lengths
	localparam logic [7:0] LEN_CHR = 8'h01;
	localparam logic [7:0] LEN_PWR = 8'h03;
	localparam logic [7:0] LEN_FRQ = 8'h01;
	localparam logic [7:0] LEN_PRV = 8'h01;
	localparam logic [7:0] HDR_LEN = 8'h02; // Tag byte plus length byte

	// Application identifier length bounds
	localparam logic [4:0] AID_MIN = 5'h01;
	localparam logic [4:0] AID_MAX = 5'h10;

	// Byte positions inside one object
	localparam logic [4:0] IDX_TAG = 5'h00;
	localparam logic [4:0] IDX_LEN = 5'h01;
	localparam logic [4:0] IDX_VAL = 5'h02;

	// Power object value positions
	localparam logic [4:0] PV_CLASS = 5'h00;
	localparam logic [4:0] PV_MA    = 5'h01;

	// Characteristics byte fields
	localparam int CHR_STOP_OK = 0;
	localparam int CHR_HIGH    = 2;
	localparam int CHR_LOW     = 3;
	localparam int CHR_VA      = 4;
	localparam int CHR_VC      = 6;
	localparam int CHR_RSV_LO  = 1;
	localparam int CHR_RSV_HI  = 7;

	localparam logic [7:0] PWR_MA_MASK = 8'h3F; // Consumption b6..b1, b8 b7 reserved
	localparam logic [7:0] NO_FREQ     = 8'hFF; // No frequency figure given

	// Master file, plain dedicated file, application directory, elementary file
	typedef enum logic [1:0] {FK_MASTER, FK_PLAIN, FK_APP, FK_ELEM} fcp_kind_t;

	typedef enum logic [2:0] {
		CS_NEVER, CS_HIGH_ONLY, CS_LOW_ONLY, CS_ANY, CS_ANY_HIGH, CS_ANY_LOW
	} fcp_stop_t;

	typedef enum logic [3:0] {
		O_IDLE, O_NAME, O_PROP, O_CHR, O_PWR, O_FRQ, O_MEM, O_PRV, O_DONE
	} fcp_obj_t;

	typedef struct packed {
		logic [7:0] vclass; // Supply class of the measurement
		logic [7:0] ma;     // Consumption in mA
		logic [7:0] ref_f;  // Reference frequency, 0.1 MHz steps
	} fcp_pwr_t;

	typedef struct packed {
		fcp_kind_t  kind;
		fcp_stop_t  stop;
		logic [2:0] volt;    // Classes C, B, A
		logic       chr_en;  // Characteristics for non-master files
		logic [1:0] pwr_cnt;
		logic [1:0] frq_cnt;
		logic       mem_en;
		logic       prv_en;
		logic [7:0] prv_tag;
		logic [7:0] prv_val;
		logic [4:0] aid_len;
	} fcp_cfg_t;

endpackage

/* core/fcp_aid_mem.sv */
/*
 * Small store for the application identifier bytes, registered read port.
 * Assumes the writer does not change the bytes while a template is sent.
 */
`timescale 1ns/10ps
module fcp_aid_mem #(
	parameter int DEPTH = 16, // Bytes held
	parameter int AW    = 4   // Address width
) (
	input  wire logic          clk_in,   // System clock
	input  wire logic          rst_n_in, // Synchronised reset, active low
	input  wire logic          we_in,    // Write strobe
	input  wire logic [AW-1:0] waddr_in, // Write address
	input  wire logic [7:0]    wdata_in, // Write data
	input  wire logic [AW-1:0] raddr_in, // Read address
	output logic      [7:0]    rdata_out // Read data, one cycle late
);

	logic [7:0] mem [DEPTH];

	// Storage has no reset so it maps onto plain RAM
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// Registered read keeps the output path short
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end

endmodule

/* core/fcp_chr_fmt.sv */
/*
 * Builds the card characteristics byte from the clock stop policy and the
 * supported supply classes. Assumes inputs are held while a template is sent.
 */
`timescale 1ns/10ps
module fcp_chr_fmt (
	input  wire logic                clk_in,   // System clock
	input  wire logic                rst_n_in, // Synchronised reset, active low
	input  wire fcp_pkg::fcp_stop_t  stop_in,  // Clock stop policy
	input  wire logic [2:0]          volt_in,  // Supported classes C, B, A
	output logic      [7:0]          chr_out   // Characteristics byte
);
	import fcp_pkg::*;

	logic [7:0] chr_nxt;

	// Unused policy codes fall back to never stopping, the safe choice
	always_comb begin
		chr_nxt = 8'h00;
		case (stop_in)
			CS_HIGH_ONLY: chr_nxt[CHR_HIGH] = 1'b1;
			CS_LOW_ONLY:  chr_nxt[CHR_LOW] = 1'b1;
			CS_ANY:       chr_nxt[CHR_STOP_OK] = 1'b1;
			CS_ANY_HIGH: begin
				chr_nxt[CHR_STOP_OK] = 1'b1;
				chr_nxt[CHR_HIGH]    = 1'b1;
			end
			CS_ANY_LOW: begin
				chr_nxt[CHR_STOP_OK] = 1'b1;
				chr_nxt[CHR_LOW]     = 1'b1;
			end
			default: chr_nxt = 8'h00;
		endcase
		chr_nxt[CHR_VC:CHR_VA] = volt_in;
		chr_nxt[CHR_RSV_HI]    = 1'b0;
		chr_nxt[CHR_RSV_LO]    = 1'b0;
	end

	// Registered so the encoder sees a settled byte
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chr_out <= 8'h00;
		end else begin
			chr_out <= chr_nxt;
		end
	end

endmodule

/* core/fcp_encoder.sv */
/*
 * Card side encoder of the file control parameter name and proprietary
 * template. It streams the bytes out with a valid/ready handshake.
 * Assumes CFG_IN, PWR_IN, FRQ_IN and MEM_FREE_IN hold steady while BUSY_OUT
 * is high, and that the identifier store is not written meanwhile.
 */
`timescale 1ns/10ps
// Summary of operation
// - Name tag 84, length one to sixteen
// - Template tag A5, single length byte
// - Private objects follow defined objects, b8 b7 set
// - Same tag objects stay contiguous, order kept
// - Characteristics object always sent for master file
// - Power objects only for application directories
// - Minimum frequency only for application directories
// - Free memory object never for elementary files
// - b1 set: stop either level, b4 b3 preference
// - b1 clear: b3 high, b4 low, none never
// - b5 b6 b7 flag classes A B C
// - Characteristics b8 and b2 forced zero
// - Power value: class, consumption, reference frequency
// - Consumption b6..b1 mA, b8 b7 zero
// - Reference frequency 0.1 MHz steps, FF none
// - Minimum frequency one byte, FF none
// - Free memory at least two bytes, MSB first
module fcp_encoder #(
	parameter int NPWR      = 2, // Power objects supplied
	parameter int NFRQ      = 2, // Minimum frequency objects supplied
	parameter int MEM_BYTES = 2  // Free memory figure width in bytes
) (
	input  wire logic                           CLOCK_IN,       // System clock
	input  wire logic                           RSTN_IN,        // Async reset, active low
	input  wire logic                           START_IN,       // Start a template
	input  wire fcp_pkg::fcp_cfg_t              CFG_IN,         // Template contents
	input  wire fcp_pkg::fcp_pwr_t [NPWR-1:0]   PWR_IN,         // Power objects, in order
	input  wire logic [NFRQ-1:0][7:0]           FRQ_IN,         // Minimum frequencies
	input  wire logic [8*MEM_BYTES-1:0]         MEM_FREE_IN,    // Free byte count
	input  wire logic                           AID_WE_IN,      // Identifier write strobe
	input  wire logic [3:0]                     AID_ADDR_IN,    // Identifier byte index
	input  wire logic [7:0]                     AID_DATA_IN,    // Identifier byte
	input  wire logic                           BYTE_READY_IN,  // Consumer takes byte
	output logic      [7:0]                     BYTE_OUT,       // Output byte
	output logic                                BYTE_VALID_OUT, // Byte valid
	output logic                                BYTE_LAST_OUT,  // Final byte
	output logic                                BUSY_OUT,       // Template in progress
	output logic                                DONE_OUT,       // Template finished
	output logic                                ERR_OUT         // Start refused
);
	import fcp_pkg::*;

	logic       rst_s1;
	logic       rst_n;
	fcp_cfg_t   cfg_r;
	logic [8:0] pres_r;
	logic [8:0] pres_nxt;
	fcp_obj_t   obj_r;
	fcp_obj_t   obj_nxt;
	fcp_obj_t   nxt_obj;
	logic [4:0] idx_r;
	logic [4:0] idx_nxt;
	logic [1:0] inst_r;
	logic [1:0] inst_nxt;
	logic [7:0] prop_len_r;
	logic [7:0] prop_len_nxt;
	logic [4:0] last_idx;
	logic [4:0] vi;
	logic [1:0] cnt_sel;
	logic       more_inst;
	logic       is_last;
	logic       slot;
	logic       load;
	logic       start_ok;
	logic       cfg_bad;
	logic [7:0] cur_byte;
	logic [7:0] aid_byte;
	logic [7:0] chr_byte;
	logic [8*MEM_BYTES-1:0] mem_sh;

	// Next object present after cur; the last entry is always present
	function automatic fcp_obj_t next_obj(input fcp_obj_t cur, input logic [8:0] pres);
		fcp_obj_t r;
		r = O_DONE;
		for (int i = int'(O_DONE); i > int'(cur); i--) begin
			if (pres[i]) begin
				r = fcp_obj_t'(i);
			end
		end
		return r;
	endfunction

	// Reset release through two flops
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Which objects a start will emit, decided by file kind, the object counts and the enables
	always_comb begin
		pres_nxt          = 9'h000;
		pres_nxt[O_NAME]  = (CFG_IN.kind == FK_APP);
		pres_nxt[O_PROP]  = 1'b1;
		pres_nxt[O_CHR]   = (CFG_IN.kind == FK_MASTER) || CFG_IN.chr_en;
		pres_nxt[O_PWR]   = (CFG_IN.kind == FK_APP) && (CFG_IN.pwr_cnt != 2'h0);
		pres_nxt[O_FRQ]   = (CFG_IN.kind == FK_APP) && (CFG_IN.frq_cnt != 2'h0);
		pres_nxt[O_MEM]   = (CFG_IN.kind != FK_ELEM) && CFG_IN.mem_en;
		pres_nxt[O_PRV]   = CFG_IN.prv_en;
		pres_nxt[O_DONE]  = 1'b1;
	end

	// Template length is the sum of the nested objects, fixed at start
	always_comb begin
		int n;
		n = 0;
		if (pres_nxt[O_CHR]) n = n + int'(HDR_LEN + LEN_CHR);
		if (pres_nxt[O_PWR]) n = n + int'(CFG_IN.pwr_cnt) * int'(HDR_LEN + LEN_PWR);
		if (pres_nxt[O_FRQ]) n = n + int'(CFG_IN.frq_cnt) * int'(HDR_LEN + LEN_FRQ);
		if (pres_nxt[O_MEM]) n = n + int'(HDR_LEN) + MEM_BYTES;
		if (pres_nxt[O_PRV]) n = n + int'(HDR_LEN + LEN_PRV);
		prop_len_nxt = 8'(n);
	end

	// Refuse identifiers out of range and more objects than supplied
	assign cfg_bad  = ((CFG_IN.kind == FK_APP) &&
			((CFG_IN.aid_len < AID_MIN) || (CFG_IN.aid_len > AID_MAX))) ||
			(int'(CFG_IN.pwr_cnt) > NPWR) || (int'(CFG_IN.frq_cnt) > NFRQ);
	assign start_ok = START_IN && !BUSY_OUT && !cfg_bad;
	assign slot     = !BYTE_VALID_OUT || BYTE_READY_IN;
	assign load     = BUSY_OUT && (obj_r != O_DONE) && slot;
	assign nxt_obj  = next_obj(obj_r, pres_r);

	// Last byte index of the current object and repeat handling
	always_comb begin
		case (obj_r)
			O_NAME:  last_idx = IDX_LEN + cfg_r.aid_len;
			O_CHR:   last_idx = IDX_LEN + LEN_CHR[4:0];
			O_PWR:   last_idx = IDX_LEN + LEN_PWR[4:0];
			O_FRQ:   last_idx = IDX_LEN + LEN_FRQ[4:0];
			O_MEM:   last_idx = IDX_LEN + 5'(MEM_BYTES);
			O_PRV:   last_idx = IDX_LEN + LEN_PRV[4:0];
			default: last_idx = IDX_LEN; // Template header only, children follow
		endcase
		cnt_sel   = (obj_r == O_PWR) ? cfg_r.pwr_cnt : cfg_r.frq_cnt;
		more_inst = ((obj_r == O_PWR) || (obj_r == O_FRQ)) &&
				((3'(inst_r) + 3'h1) < 3'(cnt_sel));
		is_last   = (idx_r == last_idx) && !more_inst && (nxt_obj == O_DONE);
	end

	// Walk position; same tag instances go out back to back in index order
	always_comb begin
		obj_nxt  = obj_r;
		idx_nxt  = idx_r;
		inst_nxt = inst_r;
		if (start_ok) begin
			obj_nxt  = next_obj(O_IDLE, pres_nxt);
			idx_nxt  = IDX_TAG;
			inst_nxt = 2'h0;
		end else if (load) begin
			if (idx_r != last_idx) begin
				idx_nxt = idx_r + 5'h01;
			end else if (more_inst) begin
				idx_nxt  = IDX_TAG;
				inst_nxt = inst_r + 2'h1;
			end else begin
				obj_nxt  = nxt_obj;
				idx_nxt  = IDX_TAG;
				inst_nxt = 2'h0;
			end
		end
	end

	// Position registers
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			obj_r  <= O_IDLE;
			idx_r  <= IDX_TAG;
			inst_r <= 2'h0;
		end else begin
			obj_r  <= obj_nxt;
			idx_r  <= idx_nxt;
			inst_r <= inst_nxt;
		end
	end

	// Configuration captured on an accepted start
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r      <= '0;
			pres_r     <= 9'h000;
			prop_len_r <= 8'h00;
		end else if (start_ok) begin
			cfg_r      <= CFG_IN;
			pres_r     <= pres_nxt;
			prop_len_r <= prop_len_nxt;
		end
	end

	// Byte for the current position
	always_comb begin
		vi       = idx_r - IDX_VAL;
		mem_sh   = MEM_FREE_IN >> (8 * (MEM_BYTES - 1 - int'(vi)));
		cur_byte = 8'h00;
		if (idx_r == IDX_TAG) begin
			case (obj_r)
				O_NAME:  cur_byte = TAG_NAME;
				O_PROP:  cur_byte = TAG_PROP;
				O_CHR:   cur_byte = TAG_CHR;
				O_PWR:   cur_byte = TAG_PWR;
				O_FRQ:   cur_byte = TAG_FRQ;
				O_MEM:   cur_byte = TAG_MEM;
				default: cur_byte = cfg_r.prv_tag | PRV_MASK;
			endcase
		end else if (idx_r == IDX_LEN) begin
			case (obj_r)
				O_NAME:  cur_byte = {3'h0, cfg_r.aid_len};
				O_PROP:  cur_byte = prop_len_r;
				O_CHR:   cur_byte = LEN_CHR;
				O_PWR:   cur_byte = LEN_PWR;
				O_FRQ:   cur_byte = LEN_FRQ;
				O_MEM:   cur_byte = 8'(MEM_BYTES);
				default: cur_byte = LEN_PRV;
			endcase
		end else begin
			case (obj_r)
				O_NAME: cur_byte = aid_byte;
				O_CHR:  cur_byte = chr_byte;
				O_PWR: begin
					if (vi == PV_CLASS) begin
						cur_byte = PWR_IN[inst_r].vclass;
					end else if (vi == PV_MA) begin
						cur_byte = PWR_IN[inst_r].ma & PWR_MA_MASK;
					end else begin
						cur_byte = PWR_IN[inst_r].ref_f;
					end
				end
				O_FRQ:   cur_byte = FRQ_IN[inst_r];
				O_MEM:   cur_byte = mem_sh[7:0];
				default: cur_byte = cfg_r.prv_val;
			endcase
		end
	end

	// Output byte stage; held unchanged while the consumer stalls
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			BYTE_OUT       <= 8'h00;
			BYTE_VALID_OUT <= 1'b0;
			BYTE_LAST_OUT  <= 1'b0;
		end else if (load) begin
			BYTE_OUT       <= cur_byte;
			BYTE_VALID_OUT <= 1'b1;
			BYTE_LAST_OUT  <= is_last;
		end else if (BYTE_READY_IN) begin
			BYTE_VALID_OUT <= 1'b0;
			BYTE_LAST_OUT  <= 1'b0;
		end
	end

	// Busy from accepted start until the last byte is taken
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			BUSY_OUT <= 1'b0;
			DONE_OUT <= 1'b0;
			ERR_OUT  <= 1'b0;
		end else begin
			DONE_OUT <= BUSY_OUT && (obj_r == O_DONE) && slot;
			ERR_OUT  <= START_IN && !BUSY_OUT && cfg_bad;
			if (start_ok) begin
				BUSY_OUT <= 1'b1;
			end else if ((obj_r == O_DONE) && slot) begin
				BUSY_OUT <= 1'b0;
			end
		end
	end

	// Read address tracks the next position so data is ready in time
	fcp_aid_mem #(
		.DEPTH (16),
		.AW    (4)
	) u_aid (
		.clk_in    (CLOCK_IN),
		.rst_n_in  (rst_n),
		.we_in     (AID_WE_IN),
		.waddr_in  (AID_ADDR_IN),
		.wdata_in  (AID_DATA_IN),
		.raddr_in  (4'(idx_nxt - IDX_VAL)),
		.rdata_out (aid_byte)
	);

	fcp_chr_fmt u_chr (
		.clk_in   (CLOCK_IN),
		.rst_n_in (rst_n),
		.stop_in  (cfg_r.stop),
		.volt_in  (cfg_r.volt),
		.chr_out  (chr_byte)
	);

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!rst_n);

	sequence s_stall;
		BYTE_VALID_OUT && !BYTE_READY_IN;
	endsequence

	sequence s_first_byte(logic [7:0] b);
		##1 BYTE_VALID_OUT && (BYTE_OUT == b);
	endsequence

	a_name_first: assert property (start_ok && CFG_IN.kind == FK_APP |=>
			s_first_byte(TAG_NAME))
		else $error("application directory did not open with name tag");
	a_prop_first: assert property (start_ok && CFG_IN.kind != FK_APP |=>
			s_first_byte(TAG_PROP))
		else $error("template did not open with template tag");
	a_name_len: assert property (load && obj_r == O_NAME && idx_r == IDX_LEN |->
			cur_byte >= 8'h01 && cur_byte <= 8'h10)
		else $error("identifier length out of range");
	a_prv_tag_bits: assert property (load && obj_r == O_PRV && idx_r == IDX_TAG |->
			cur_byte[7:6] == 2'b11)
		else $error("private tag lacks top bits");
	a_stall_hold: assert property (s_stall |=> BYTE_VALID_OUT && $stable(BYTE_OUT))
		else $error("byte changed under stall");
	a_inst_order: assert property (load && more_inst && idx_r == last_idx |=>
			inst_r == $past(inst_r) + 2'h1 && idx_r == IDX_TAG)
		else $error("repeated objects out of order");
	a_chr_master: assert property (start_ok && CFG_IN.kind == FK_MASTER |=>
			pres_r[O_CHR])
		else $error("master file lacks characteristics");
	a_pwr_app_only: assert property (obj_r == O_PWR |-> cfg_r.kind == FK_APP)
		else $error("power object outside application directory");
	a_frq_app_only: assert property (obj_r == O_FRQ |-> cfg_r.kind == FK_APP)
		else $error("frequency object outside application directory");
	a_mem_not_elem: assert property (obj_r == O_MEM |-> cfg_r.kind != FK_ELEM)
		else $error("memory object for elementary file");
	a_chr_never: assert property (load && obj_r == O_CHR && idx_r == IDX_VAL &&
			cfg_r.stop == CS_NEVER |-> cur_byte[3:2] == 2'b00 && !cur_byte[0])
		else $error("never-stop policy encoded wrongly");
	a_chr_reserved: assert property (load && obj_r == O_CHR && idx_r == IDX_VAL |->
			!cur_byte[7] && !cur_byte[1] && cur_byte[6:4] == cfg_r.volt)
		else $error("characteristics reserved bits or classes wrong");
	a_pwr_rsv: assert property (load && obj_r == O_PWR && idx_r == IDX_VAL + 5'h01 |->
			cur_byte[7:6] == 2'b00)
		else $error("consumption reserved bits set");
	a_done_after: assert property (BYTE_VALID_OUT && BYTE_READY_IN && BYTE_LAST_OUT |=>
			DONE_OUT && !BUSY_OUT && !BYTE_VALID_OUT)
		else $error("done not raised after last byte");

endmodule

/* bench/fcp_term_model.sv */
/*
 * Terminal side model that takes the encoder's byte stream and keeps it in order.
 * Assumes one system clock and a reset shared with the encoder.
 */
`timescale 1ns/10ps
module fcp_term_model #(
	parameter logic [7:0] USE_CLASS = 8'h01 // Supply class the terminal runs at
) (
	input  wire logic       clk_in,   // System clock
	input  wire logic       rst_n_in, // Reset, active low
	input  wire logic       slow_in,  // Stall three cycles in four
	input  wire logic [7:0] byte_in,  // Byte from the card
	input  wire logic       valid_in, // Byte valid
	input  wire logic       last_in,  // Final byte
	output logic            ready_out // Byte taken
);
	import fcp_pkg::*;

	logic [1:0] cnt_r;
	logic [7:0] got[$];
	int         last_pos;
	int         p;
	int         tend;
	int         malformed;  // Nested objects running past the template
	int         pwr_used;   // Consumption figures the terminal interprets
	int         pwr_scaled; // Of those, measured at another supply class

	// Pacing, so a slow terminal holds the card off mid-object
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 2'h0;
			ready_out <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			ready_out <= !slow_in || (cnt_r == 2'h3);
		end
	end

	// Bytes kept in arrival order; same-tag objects keep their meaning by order.
	// On the final byte the terminal reads the template: unknown objects are
	// stepped over by their length, so only an overrun makes it malformed.
	always @(posedge clk_in) begin
		if (valid_in && ready_out) begin
			got.push_back(byte_in);
			if (last_in) begin
				last_pos   = got.size() - 1;
				malformed  = 0;
				pwr_used   = 0;
				pwr_scaled = 0;
				p          = (got[0] == TAG_NAME) ? int'(got[1]) + 2 : 0;
				tend       = p + 2 + int'(got[p + 1]);
				if (tend > got.size()) begin
					malformed++;
					tend = got.size();
				end
				p = p + 2;
				while (p < tend) begin
					if (p + 2 > tend || p + 2 + int'(got[p + 1]) > tend) begin
						malformed++;
						break;
					end
					// 00, FF and anything above 3C carry no usable figure
					if (got[p] == TAG_PWR && got[p + 1] == LEN_PWR && got[p + 3] != 8'h00 &&
							got[p + 3] != 8'hFF && got[p + 3] <= 8'h3C) begin
						pwr_used++;
						if (got[p + 2] != USE_CLASS) begin
							pwr_scaled++;
						end
					end
					p = p + 2 + int'(got[p + 1]);
				end
			end
		end
	end
endmodule

/* bench/fcp_encoder_tb_top.sv */
/*
 * Self-checking bench for the template encoder with a terminal model.
 * Assumes the encoder's own assertions run alongside.
 */
`timescale 1ns/10ps
module fcp_encoder_tb_top;
	import fcp_pkg::*;
	logic                clk;
	logic                rstn;
	logic                start;
	logic                slow;
	fcp_cfg_t            cfg;
	fcp_pwr_t [1:0]      pwr;
	logic [1:0][7:0]     frq;
	logic [15:0]         mem;
	logic                we;
	logic [3:0]          addr;
	logic [7:0]          data;
	logic                ready;
	logic [7:0]          byte_o;
	logic                valid;
	logic                last;
	logic                busy;
	logic                done;
	logic                err;
	int                  mismatches = 0;
	int                  tests_run = 0;
	int                  cycles = 0;
	logic [7:0]          exp[$];

	fcp_encoder dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .START_IN(start), .CFG_IN(cfg),
		.PWR_IN(pwr), .FRQ_IN(frq), .MEM_FREE_IN(mem), .AID_WE_IN(we), .AID_ADDR_IN(addr),
		.AID_DATA_IN(data), .BYTE_READY_IN(ready), .BYTE_OUT(byte_o), .BYTE_VALID_OUT(valid),
		.BYTE_LAST_OUT(last), .BUSY_OUT(busy), .DONE_OUT(done), .ERR_OUT(err));

	fcp_term_model term (.clk_in(clk), .rst_n_in(rstn), .slow_in(slow), .byte_in(byte_o),
		.valid_in(valid), .last_in(last), .ready_out(ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: a run far beyond the expected few hundred cycles is a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic results();
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One template end to end, compared byte for byte with exp
	task automatic run_case(input fcp_cfg_t c, input logic s);
		int n;
		n = 0;
		term.got.delete();
		term.last_pos = -1;
		@(posedge clk);
		cfg <= c;
		slow <= s;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		chk({7'h0, busy}, 8'h01);
		while (done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk({7'h0, done}, 8'h01);
		chk(8'(term.got.size()), 8'(exp.size()));
		foreach (exp[i]) begin
			chk(term.got[i], exp[i]);
		end
		chk(8'(term.last_pos), 8'(exp.size() - 1));
		chk(8'(term.malformed), 8'h00);
		@(negedge clk);
		chk({6'h0, done, busy}, 8'h00);
	endtask

	task automatic t_master_walk();
		exp = '{8'hA5, 8'h03, 8'h80, 8'h01, 8'h11};
		run_case('{kind: FK_MASTER, stop: CS_ANY, volt: 3'h1, default: '0}, 1'b0);
	endtask

	// Every stop policy with all classes: b1, b3, b4 and class bits, b2 b8 zero
	task automatic t_stop_table();
		fcp_stop_t  pol[6] = '{CS_NEVER, CS_HIGH_ONLY, CS_LOW_ONLY, CS_ANY, CS_ANY_HIGH, CS_ANY_LOW};
		logic [7:0] chr[6] = '{8'h70, 8'h74, 8'h78, 8'h71, 8'h75, 8'h79};
		for (int i = 0; i < 6; i++) begin
			exp = '{8'hA5, 8'h03, 8'h80, 8'h01, chr[i]};
			run_case('{kind: FK_MASTER, stop: pol[i], volt: 3'h7, default: '0}, 1'b0);
		end
	endtask

	// Full application directory template, longest identifier, slow terminal
	task automatic t_appdir_full();
		fcp_cfg_t c;
		c = '{kind: FK_APP, stop: CS_HIGH_ONLY, volt: 3'h2, chr_en: 1'b1, pwr_cnt: 2'h2,
			frq_cnt: 2'h2, mem_en: 1'b1, prv_en: 1'b1, prv_tag: 8'h1F, prv_val: 8'h5A,
			aid_len: 5'h10};
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			we <= 1'b1;
			addr <= 4'(i);
			data <= 8'h30 + 8'(i);
		end
		@(posedge clk);
		we <= 1'b0;
		pwr <= '{'{8'h04, 8'h3C, 8'hFF}, '{8'h01, 8'hFF, 8'h0A}};
		frq <= '{8'hFF, 8'h0A};
		mem <= 16'hBEEF;
		exp = '{8'h84, 8'h10};
		for (int i = 0; i < 16; i++) begin
			exp.push_back(8'h30 + 8'(i));
		end
		exp = {exp, 8'hA5, 8'h1A, 8'h80, 8'h01, 8'h24, 8'h81, 8'h03, 8'h01, 8'h3F, 8'h0A,
			8'h81, 8'h03, 8'h04, 8'h3C, 8'hFF, 8'h82, 8'h01, 8'h0A, 8'h82, 8'h01, 8'hFF,
			8'h83, 8'h02, 8'hBE, 8'hEF, 8'hDF, 8'h01, 8'h5A};
		run_case(c, 1'b1);
		chk(8'(term.pwr_used), 8'h01);
		chk(8'(term.pwr_scaled), 8'h01);
	endtask

	// Power and frequency objects withheld outside application directories
	task automatic t_kind_gate();
		exp = '{8'hA5, 8'h00};
		run_case('{kind: FK_ELEM, stop: CS_NEVER, pwr_cnt: 2'h1, frq_cnt: 2'h1, mem_en: 1'b1,
			default: '0}, 1'b0);
		exp = '{8'hA5, 8'h04, 8'h83, 8'h02, 8'hBE, 8'hEF};
		run_case('{kind: FK_PLAIN, stop: CS_NEVER, pwr_cnt: 2'h1, frq_cnt: 2'h1, mem_en: 1'b1,
			default: '0}, 1'b0);
	endtask

	// Identifier lengths outside one to sixteen and too many power objects
	task automatic t_refuse();
		logic [4:0] len[3] = '{5'h00, 5'h11, 5'h01};
		logic [1:0] np[3] = '{2'h0, 2'h0, 2'h3};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			cfg <= '{kind: FK_APP, stop: CS_NEVER, aid_len: len[i], pwr_cnt: np[i], default: '0};
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			@(negedge clk);
			chk({6'h0, err, busy}, 8'h02);
			@(negedge clk);
			chk({6'h0, err, busy}, 8'h00);
		end
	endtask

	initial begin
		rstn = 1'b0;
		start = 1'b0;
		slow = 1'b0;
		cfg = '0;
		pwr = '0;
		frq = '0;
		mem = '0;
		we = 1'b0;
		addr = 4'h0;
		data = 8'h00;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_master_walk();
		t_stop_table();
		t_appdir_full();
		t_kind_gate();
		t_refuse();
		results();
	end
endmodule
